// file: verilog/rocr_pkg.sv
// Package: offsets, field positions, reset values for the RTC oscillator/capture/alarm block
package rocr_pkg;
    // Printed offsets are not all multiples of four: indices, byte address = 4 * index
    localparam logic [7:0] IDX_SNAP0     = 8'h00;
    localparam logic [7:0] IDX_SNAP1     = 8'h01;
    localparam logic [7:0] IDX_SNAP2     = 8'h02;
    localparam logic [7:0] IDX_SNAP3     = 8'h03;
    localparam logic [7:0] IDX_TMR_CTL   = 8'h04;
    localparam logic [7:0] IDX_OSC_CTL   = 8'h05;
    localparam logic [7:0] IDX_OSC_CFG   = 8'h06;
    localparam logic [7:0] IDX_PIN_CFG   = 8'h07;
    localparam logic [7:0] IDX_MATCH0    = 8'h08;
    localparam logic [7:0] IDX_MATCH1    = 8'h09;
    localparam logic [7:0] IDX_MATCH2    = 8'h0a;
    localparam logic [7:0] IDX_MATCH3    = 8'h0b;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h0d;

    // Oscillator control fields
    localparam int OSC_GAIN_BIT  = 7;
    localparam int OSC_MODE_BIT  = 6;
    localparam int OSC_BIAS_BIT  = 5;
    localparam int OSC_AMP_BIT   = 4;
    // Oscillator config fields
    localparam int CFG_STEP_BIT  = 7;
    localparam int CFG_DONE_BIT  = 6;
    // Timer control fields
    localparam int TMR_LOAD_BIT  = 1;
    localparam int TMR_SNAP_BIT  = 0;
    localparam int TMR_MEV_BIT   = 3;
    // Interrupt status fields
    localparam int IRQ_LOAD_BIT  = 0;
    localparam int IRQ_SNAP_BIT  = 1;
    localparam int IRQ_CAP_BIT   = 2;
    localparam int IRQ_W         = 3;

    localparam logic [7:0] PIN_SHORT_CODE  = 8'he7;
    localparam logic [7:0] PIN_NORMAL_CODE = 8'h67;
    localparam logic [7:0] PIN_CFG_RST     = 8'h67;
    localparam logic [3:0] LOAD_CAP_RST    = 4'h0;
    localparam logic [31:0] MATCH_RST      = 32'h0000_0000;
    localparam logic [31:0] SNAP_RST       = 32'h0000_0000;

    typedef struct packed {
        logic       gain_en;
        logic       mode_sel;
        logic       bias_dbl;
        logic       step_en;
        logic [3:0] cap_value;
        logic       pins_shorted;
    } rocr_osc_type;
endpackage

// file: verilog/rocr_regs.sv
// RTC oscillator control, timer snapshot window and match value registers on AHB-Lite
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module rocr_regs (
    input  wire logic                 ref_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic      [31:0]          hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    input  wire logic                 osc_amplitude_ok_i,
    input  wire logic                 cap_load_done_i,
    output logic                      timer_load_go_o,
    output logic                      timer_snapshot_go_o,
    input  wire logic                 timer_load_ack_i,
    input  wire logic                 timer_snapshot_ack_i,
    input  wire logic [31:0]          timer_value_i,
    output logic      [31:0]          timer_load_value_o,
    output logic      [31:0]          match_value_o,
    output logic                      match_event_en_o,
    output rocr_pkg::rocr_osc_type    osc_cfg_o,
    output logic                      irq_o
);
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic        rd_go;
    logic [7:0]  rd_idx;
    logic        access;
    logic [7:0]  wbyte;
    logic [31:0] snap_q;
    logic [31:0] match_q;
    logic        load_q;
    logic        snapq_q;
    logic        mev_q;
    logic        gain_q;
    logic        mode_q;
    logic        bias_q;
    logic        step_q;
    logic [3:0]  cap_q;
    logic        short_q;
    logic [rocr_pkg::IRQ_W-1:0] stat_q;
    logic [rocr_pkg::IRQ_W-1:0] mask_q;
    logic [rocr_pkg::IRQ_W-1:0] ev;
    logic        cap_done_d1_q;
    logic [7:0]  rbyte;

    // Zero wait state slave: always ready, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign access      = hsel_i && htrans_i[1] && hready_i;
    assign rd_go       = access && !hwrite_i;
    assign rd_idx      = haddr_i[9:2];
    assign wbyte       = hwdata_i[7:0];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            wr_pend_q <= access && hwrite_i;
            wr_idx_q  <= haddr_i[9:2];
        end
    end

    function automatic logic wr_hit(input logic [7:0] idx);
        wr_hit = wr_pend_q && (wr_idx_q == idx);
    endfunction

    // Oscillator control and config
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gain_q <= 1'b0;
            mode_q <= 1'b0;
            bias_q <= 1'b0;
            step_q <= 1'b0;
            cap_q  <= rocr_pkg::LOAD_CAP_RST;
        end else begin
            if (wr_hit(rocr_pkg::IDX_OSC_CTL)) begin
                gain_q <= wbyte[rocr_pkg::OSC_GAIN_BIT];
                mode_q <= wbyte[rocr_pkg::OSC_MODE_BIT];
                bias_q <= wbyte[rocr_pkg::OSC_BIAS_BIT];
            end
            if (wr_hit(rocr_pkg::IDX_OSC_CFG)) begin
                step_q <= wbyte[rocr_pkg::CFG_STEP_BIT];
                cap_q  <= wbyte[3:0];
            end
        end
    end

    // Pin short: only the two codes act, other values leave the pins alone
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            short_q <= 1'b0;
        end else if (wr_hit(rocr_pkg::IDX_PIN_CFG)) begin
            if (wbyte == rocr_pkg::PIN_SHORT_CODE) begin
                short_q <= 1'b1;
            end else if (wbyte == rocr_pkg::PIN_NORMAL_CODE) begin
                short_q <= 1'b0;
            end
        end
    end

    // Snapshot window
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap_q <= rocr_pkg::SNAP_RST;
        end else if (snapq_q && timer_snapshot_ack_i) begin
            snap_q <= timer_value_i;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_hit(8'(i))) begin
                    snap_q[8*i +: 8] <= wbyte;
                end
            end
        end
    end

    // Match value
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            match_q <= rocr_pkg::MATCH_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_hit(rocr_pkg::IDX_MATCH0 + 8'(i))) begin
                    match_q[8*i +: 8] <= wbyte;
                end
            end
        end
    end

    // Timer command bits; completion from the timer clears load and snapshot, match enable keeps its value
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_q  <= 1'b0;
            snapq_q <= 1'b0;
            mev_q   <= 1'b0;
        end else begin
            if (load_q && timer_load_ack_i) begin
                load_q <= 1'b0;
            end else if (wr_hit(rocr_pkg::IDX_TMR_CTL) && wbyte[rocr_pkg::TMR_LOAD_BIT]) begin
                load_q <= 1'b1;
            end
            if (snapq_q && timer_snapshot_ack_i) begin
                snapq_q <= 1'b0;
            end else if (wr_hit(rocr_pkg::IDX_TMR_CTL) && wbyte[rocr_pkg::TMR_SNAP_BIT]) begin
                snapq_q <= 1'b1;
            end
            if (wr_hit(rocr_pkg::IDX_TMR_CTL)) begin
                mev_q <= wbyte[rocr_pkg::TMR_MEV_BIT];
            end
        end
    end

    // Interrupt events: load done, snapshot done, capacitance reached
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_done_d1_q <= 1'b0;
        end else begin
            cap_done_d1_q <= cap_load_done_i;
        end
    end

    always_comb begin
        ev = '0;
        ev[rocr_pkg::IRQ_LOAD_BIT] = load_q && timer_load_ack_i;
        ev[rocr_pkg::IRQ_SNAP_BIT] = snapq_q && timer_snapshot_ack_i;
        ev[rocr_pkg::IRQ_CAP_BIT]  = cap_load_done_i && !cap_done_d1_q;
    end

    // Set wins over read clear so no event is lost
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            if (rd_go && rd_idx == rocr_pkg::IDX_IRQ_STAT) begin
                stat_q <= ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            if (wr_hit(rocr_pkg::IDX_IRQ_MASK)) begin
                mask_q <= hwdata_i[rocr_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(stat_q & mask_q);

    // Read mux; unmapped indices read zero
    always_comb begin
        rbyte = 8'h00;
        unique case (rd_idx)
            rocr_pkg::IDX_SNAP0, rocr_pkg::IDX_SNAP1,
            rocr_pkg::IDX_SNAP2, rocr_pkg::IDX_SNAP3: rbyte = snap_q[8*rd_idx[1:0] +: 8];
            rocr_pkg::IDX_TMR_CTL: rbyte = {4'h0, mev_q, 1'b0, load_q, snapq_q};
            rocr_pkg::IDX_OSC_CTL: rbyte = {gain_q, mode_q, bias_q, osc_amplitude_ok_i, 4'h0};
            rocr_pkg::IDX_OSC_CFG: rbyte = {step_q, cap_load_done_i, 2'b00, cap_q};
            rocr_pkg::IDX_MATCH0, rocr_pkg::IDX_MATCH1,
            rocr_pkg::IDX_MATCH2, rocr_pkg::IDX_MATCH3: rbyte = match_q[8*rd_idx[1:0] +: 8];
            rocr_pkg::IDX_IRQ_STAT: rbyte = {5'h00, stat_q};
            rocr_pkg::IDX_IRQ_MASK: rbyte = {5'h00, mask_q};
            default: rbyte = 8'h00;
        endcase
    end

    // Pin config is write only and reads zero
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_go) begin
            hrdata_o <= {24'h000000, rbyte};
        end
    end

    assign timer_load_go_o     = load_q;
    assign timer_snapshot_go_o = snapq_q;
    assign timer_load_value_o  = snap_q;
    assign match_value_o       = match_q;
    assign match_event_en_o    = mev_q;
    assign osc_cfg_o = '{gain_en: gain_q, mode_sel: mode_q, bias_dbl: bias_q,
                         step_en: step_q, cap_value: cap_q, pins_shorted: short_q};

    chk_load_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        load_q && timer_load_ack_i |=> !load_q) else $error("load bit not cleared");
    chk_snap_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        snapq_q && timer_snapshot_ack_i |=> !snapq_q) else $error("snapshot bit not cleared");
    chk_snap_copy: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        snapq_q && timer_snapshot_ack_i |=> snap_q == $past(timer_value_i))
        else $error("snapshot not copied");
    chk_pin_short: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_hit(rocr_pkg::IDX_PIN_CFG) && wbyte == rocr_pkg::PIN_SHORT_CODE
        |=> osc_cfg_o.pins_shorted)
        else $error("pins not shorted");
    chk_pin_normal: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_hit(rocr_pkg::IDX_PIN_CFG) && wbyte == rocr_pkg::PIN_NORMAL_CODE
        |=> !osc_cfg_o.pins_shorted)
        else $error("pins not restored");
    chk_ctl_low_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        rd_go && rd_idx == rocr_pkg::IDX_OSC_CTL |=> hrdata_o[3:0] == 4'h0)
        else $error("control low nibble not zero");
    chk_cfg_mid_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        rd_go && rd_idx == rocr_pkg::IDX_OSC_CFG |=> hrdata_o[5:4] == 2'b00)
        else $error("config bits 5:4 not zero");
    chk_match_byte0: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_hit(rocr_pkg::IDX_MATCH0) |=> match_value_o[7:0] == $past(wbyte))
        else $error("match byte zero misplaced");
    chk_gain_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_hit(rocr_pkg::IDX_OSC_CTL) |=> osc_cfg_o.gain_en == $past(wbyte[rocr_pkg::OSC_GAIN_BIT]))
        else $error("gain enable not written");

    // Bus steps seen by the slave: address phase, then data phase
    sequence s_ctl_write;
        access && hwrite_i && (haddr_i[9:2] == rocr_pkg::IDX_OSC_CTL) ##1 wr_pend_q;
    endsequence
    sequence s_cfg_write;
        access && hwrite_i && (haddr_i[9:2] == rocr_pkg::IDX_OSC_CFG) ##1 wr_pend_q;
    endsequence
    sequence s_pin_write;
        access && hwrite_i && (haddr_i[9:2] == rocr_pkg::IDX_PIN_CFG) ##1 wr_pend_q;
    endsequence
    sequence s_cmd_write;
        access && hwrite_i && (haddr_i[9:2] == rocr_pkg::IDX_TMR_CTL) ##1 wr_pend_q;
    endsequence
    sequence s_ctl_read;
        rd_go && (rd_idx == rocr_pkg::IDX_OSC_CTL) ##1 hreadyout_o;
    endsequence
    sequence s_cfg_read;
        rd_go && (rd_idx == rocr_pkg::IDX_OSC_CFG) ##1 hreadyout_o;
    endsequence
    sequence s_load_done;
        load_q && timer_load_ack_i;
    endsequence
    sequence s_snap_done;
        snapq_q && timer_snapshot_ack_i;
    endsequence

    // Oscillator fields
    chk_mode_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_ctl_write |=> osc_cfg_o.mode_sel == $past(wbyte[rocr_pkg::OSC_MODE_BIT]))
        else $error("mode select not written");
    chk_bias_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_ctl_write |=> osc_cfg_o.bias_dbl == $past(wbyte[rocr_pkg::OSC_BIAS_BIT]))
        else $error("bias double not written");
    chk_ctl_readback: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_ctl_read |-> hrdata_o[7:5] ==
        $past({osc_cfg_o.gain_en, osc_cfg_o.mode_sel, osc_cfg_o.bias_dbl}))
        else $error("control fields read back wrong");
    chk_amp_read: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_ctl_read |-> hrdata_o[rocr_pkg::OSC_AMP_BIT] == $past(osc_amplitude_ok_i))
        else $error("amplitude status read wrong");
    chk_step_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_cfg_write |=> osc_cfg_o.step_en == $past(wbyte[rocr_pkg::CFG_STEP_BIT]))
        else $error("auto step enable not written");
    chk_done_read: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_cfg_read |-> hrdata_o[rocr_pkg::CFG_DONE_BIT] == $past(cap_load_done_i))
        else $error("capacitance ready read wrong");
    chk_cap_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_cfg_write |=> osc_cfg_o.cap_value == $past(wbyte[3:0]))
        else $error("capacitance value not written");
    chk_cap_read: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_cfg_read |-> hrdata_o[3:0] == $past(osc_cfg_o.cap_value))
        else $error("capacitance value read wrong");
    chk_pin_other: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_pin_write ##0 (wbyte != rocr_pkg::PIN_SHORT_CODE && wbyte != rocr_pkg::PIN_NORMAL_CODE)
        |=> $stable(osc_cfg_o.pins_shorted))
        else $error("pin state moved on unknown code");

    // Snapshot and match windows move only on their own writes or commands
    chk_snap_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !(snapq_q && timer_snapshot_ack_i) && !(wr_pend_q && wr_idx_q[7:2] == 6'h00)
        |=> $stable(timer_load_value_o))
        else $error("snapshot changed without cause");
    chk_snap_byte0: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_hit(rocr_pkg::IDX_SNAP0) && !(snapq_q && timer_snapshot_ack_i)
        |=> timer_load_value_o[7:0] == $past(wbyte))
        else $error("snapshot byte zero misplaced");
    chk_snap_byte3: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_hit(rocr_pkg::IDX_SNAP3) && !(snapq_q && timer_snapshot_ack_i)
        |=> timer_load_value_o[31:24] == $past(wbyte))
        else $error("snapshot byte three misplaced");
    chk_load_idle: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !load_q && !(wr_pend_q && wr_idx_q == rocr_pkg::IDX_TMR_CTL) |=> !load_q)
        else $error("load started without command");
    chk_match_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !(wr_pend_q && wr_idx_q[7:2] == 6'h02) |=> $stable(match_value_o))
        else $error("match value changed without write");
    chk_match_byte3: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_hit(rocr_pkg::IDX_MATCH3) |=> match_value_o[31:24] == $past(wbyte))
        else $error("match byte three misplaced");

    // Command bits stay up until the timer answers
    chk_load_start: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_cmd_write ##0 (wbyte[rocr_pkg::TMR_LOAD_BIT] && !timer_load_ack_i)
        |=> timer_load_go_o)
        else $error("load command not raised");
    chk_snap_start: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_cmd_write ##0 (wbyte[rocr_pkg::TMR_SNAP_BIT] && !timer_snapshot_ack_i)
        |=> timer_snapshot_go_o)
        else $error("snapshot command not raised");
    chk_load_wait: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        load_q && !timer_load_ack_i |=> timer_load_go_o)
        else $error("load command dropped early");
    chk_snap_wait: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        snapq_q && !timer_snapshot_ack_i |=> timer_snapshot_go_o)
        else $error("snapshot command dropped early");
    chk_mev_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_cmd_write |=> match_event_en_o == $past(wbyte[rocr_pkg::TMR_MEV_BIT]))
        else $error("match enable not written");

    // Interrupt flags: a set in the read cycle survives the clear
    chk_load_event: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_load_done |=> stat_q[rocr_pkg::IRQ_LOAD_BIT])
        else $error("load event lost");
    chk_snap_event: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_snap_done |=> stat_q[rocr_pkg::IRQ_SNAP_BIT])
        else $error("snapshot event lost");
    chk_stat_sticky: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        |ev |=> (stat_q & $past(ev)) == $past(ev))
        else $error("status event not kept");
    chk_stat_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        rd_go && rd_idx == rocr_pkg::IDX_IRQ_STAT && ev == '0 |=> stat_q == '0)
        else $error("status not cleared by read");
endmodule

// file: testbench/rocr_tb.sv
// Self-checking testbench for the RTC oscillator, snapshot and match registers
`timescale 1ns/1ps
module testbench;
    logic                   clk;
    logic                   resetn;
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    logic [31:0]            hrdata;
    logic                   hready;
    logic                   hresp;
    logic                   amp_ok;
    logic                   cap_done;
    logic                   load_ack;
    logic                   snap_ack;
    logic [31:0]            tmr_val;
    logic                   load_go;
    logic                   snap_go;
    logic [31:0]            load_val;
    logic [31:0]            match_val;
    logic                   match_en;
    logic                   irq;
    rocr_pkg::rocr_osc_type osc_cfg;
    logic [31:0]            rd;
    int                     n_mismatch = 0;
    int                     check_count = 0;
    int                     cycles = 0;

    rocr_regs rocr_regs_i (
        .ref_clk_i            (clk),
        .resetn_i             (resetn),
        .hsel_i               (hsel),
        .haddr_i              (haddr),
        .htrans_i             (htrans),
        .hwrite_i             (hwrite),
        .hsize_i              (hsize),
        .hwdata_i             (hwdata),
        .hready_i             (hready),
        .hrdata_o             (hrdata),
        .hreadyout_o          (hready),
        .hresp_o              (hresp),
        .osc_amplitude_ok_i   (amp_ok),
        .cap_load_done_i      (cap_done),
        .timer_load_go_o      (load_go),
        .timer_snapshot_go_o  (snap_go),
        .timer_load_ack_i     (load_ack),
        .timer_snapshot_ack_i (snap_ack),
        .timer_value_i        (tmr_val),
        .timer_load_value_o   (load_val),
        .match_value_o        (match_val),
        .match_event_en_o     (match_en),
        .osc_cfg_o            (osc_cfg),
        .irq_o                (irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic addr_ph(input logic [7:0] idx, input logic wr);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
    endtask
    task automatic ahb_wr(input logic [7:0] idx, input logic [7:0] d);
        addr_ph(idx, 1'b1);
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
    endtask
    task automatic ahb_rd(input logic [7:0] idx);
        addr_ph(idx, 1'b0);
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        ahb_rd(idx);
        chk32(rd, {24'h0, exp});
        chk1(hresp, 1'b0);
    endtask
    // Ack strobes last exactly one cycle, as the timer side gives them
    task automatic pulse(input logic is_load);
        @(posedge clk);
        if (is_load) load_ack <= 1'b1;
        else snap_ack <= 1'b1;
        @(posedge clk);
        load_ack <= 1'b0;
        snap_ack <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        logic [31:0] v;
        resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; amp_ok = 1'b0; cap_done = 1'b0;
        load_ack = 1'b0; snap_ack = 1'b0; tmr_val = 32'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk32({23'h0, osc_cfg}, 32'h0);
        chk32(match_val, 32'h0);
        for (int i = 0; i < 4; i++) rd_chk(8'(i), 8'h00);
        for (int i = 8; i < 12; i++) rd_chk(8'(i), 8'h00);
        rd_chk(8'h05, 8'h00);
        $display("test reset finished");
        for (int b = 5; b < 8; b++) begin
            ahb_wr(8'h05, (8'h01 << b) | 8'h0f);
            rd_chk(8'h05, 8'h01 << b);
        end
        @(posedge clk) amp_ok <= 1'b1;
        rd_chk(8'h05, 8'h90);
        ahb_wr(8'h05, 8'hef);
        rd_chk(8'h05, 8'hf0);
        $display("test oscillator control finished");
        ahb_wr(8'h06, 8'hff);
        rd_chk(8'h06, 8'h8f);
        @(posedge clk) cap_done <= 1'b1;
        rd_chk(8'h06, 8'hcf);
        ahb_wr(8'h06, 8'h35);
        rd_chk(8'h06, 8'h45);
        ahb_wr(8'h06, 8'hfa);
        @(negedge clk);
        chk32({23'h0, osc_cfg}, 32'h1f4);
        $display("test oscillator config finished");
        ahb_wr(8'h07, 8'he7);
        @(negedge clk);
        chk1(osc_cfg.pins_shorted, 1'b1);
        ahb_wr(8'h07, 8'h55);
        @(negedge clk);
        chk1(osc_cfg.pins_shorted, 1'b1);
        ahb_wr(8'h07, 8'h67);
        @(negedge clk);
        chk1(osc_cfg.pins_shorted, 1'b0);
        rd_chk(8'h07, 8'h00);
        $display("test pin config finished");
        v = 32'h44332211;
        for (int i = 0; i < 4; i++) ahb_wr(8'(i), v[8*i +: 8]);
        @(negedge clk);
        chk32(load_val, v);
        chk1(load_go, 1'b0);
        ahb_wr(8'h04, 8'h02);
        @(negedge clk);
        chk1(load_go, 1'b1);
        chk1(snap_go, 1'b0);
        pulse(1'b1);
        chk1(load_go, 1'b0);
        @(posedge clk) tmr_val <= 32'hdeadbeef;
        rd_chk(8'h00, 8'h11);
        ahb_wr(8'h04, 8'h01);
        @(negedge clk);
        chk1(snap_go, 1'b1);
        pulse(1'b0);
        chk1(snap_go, 1'b0);
        v = 32'hdeadbeef;
        for (int i = 0; i < 4; i++) rd_chk(8'(i), v[8*i +: 8]);
        $display("test snapshot finished");
        ahb_wr(8'h04, 8'h08);
        rd_chk(8'h04, 8'h08);
        chk1(match_en, 1'b1);
        ahb_wr(8'h04, 8'h00);
        @(negedge clk);
        chk1(match_en, 1'b0);
        v = 32'hd4c3b2a1;
        for (int i = 0; i < 4; i++) ahb_wr(8'(8 + i), v[8*i +: 8]);
        @(negedge clk);
        chk32(match_val, v);
        for (int i = 0; i < 4; i++) rd_chk(8'(8 + i), v[8*i +: 8]);
        $display("test match finished");
        chk1(irq, 1'b0);
        rd_chk(8'h0c, 8'h07);
        rd_chk(8'h0c, 8'h00);
        ahb_wr(8'h04, 8'h02);
        pulse(1'b1);
        chk1(irq, 1'b0);
        ahb_wr(8'h0d, 8'h01);
        @(negedge clk);
        chk1(irq, 1'b1);
        rd_chk(8'h0d, 8'h01);
        rd_chk(8'h0c, 8'h01);
        @(negedge clk);
        chk1(irq, 1'b0);
        // Unmapped place must neither store nor disturb a neighbour
        ahb_wr(8'h20, 8'hff);
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h08, 8'ha1);
        $display("test interrupt and unmapped finished");
        wrap_up();
    end
endmodule
